// ===== hw/flash_host_params.svh
// Constants for the parallel NOR flash host controller.
// Assumes a 20 MHz clk_in; all times are converted to cycles here.
// Functional notes
// - After reset release, wait the release-to-read interval before reading.
// - Operation cut by a reset is reissued once the device runs again (the controller does not reissue; the caller must).
// - Word program is always preceded by the three-cycle unlock.
// - Every erase goes out as the full six-cycle unlock sequence.
// - Query entry by three cycles ending 98H at address 555H.
// - Query entry by a single write of 98H at address 55H.
// - Query mode lasts until the exit command is written.
// - Exit sequence returns to array read and recovers from faults (the controller refuses the exit while busy_in is high).
// - Security words use their own program command; toggle-bit polling (the controller does no polling).
// - Security space entry by 88H at 555H; left by the exit command.
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

`define CLK_PERIOD_NS     50
`define STROBE_LOW_NS     100
`define STROBE_LOW_CYC    ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_NS    1000
`define RESET_PULSE_CYC   ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELEASE_READ_NS   1000
`define RELEASE_READ_CYC  ((`RELEASE_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLE_NS     70
`define READ_CYCLE_CYC    ((`READ_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ADDR_UNLOCK1      21'h000555
`define ADDR_UNLOCK2      21'h0002AA
`define ADDR_QUERY_SHORT  21'h000055
`define ADDR_LOCK_STATUS  21'h0000FF
`define DATA_UNLOCK1      16'h00AA
`define DATA_UNLOCK2      16'h0055
`define CMD_PROGRAM       16'h00A0
`define CMD_ERASE_SETUP   16'h0080
`define CMD_SECTOR_ERASE  16'h0050
`define CMD_BLOCK_ERASE   16'h0030
`define CMD_CHIP_ERASE    16'h0010
`define CMD_SEC_ENTRY     16'h0088
`define CMD_SEC_PROGRAM   16'h00A5
`define CMD_SEC_LOCK      16'h0085
`define CMD_ID_ENTRY      16'h0090
`define CMD_QUERY_ENTRY   16'h0098
`define CMD_EXIT          16'h00F0
`define DATA_LOCK_WORD    16'h0000

`define BOOT_TOP_BASE     21'h1F8000
`define BOOT_BOTTOM_LAST  21'h007FFF
`define SEC_FACTORY_LAST  21'h000007
`define SEC_USER_FIRST    21'h000008
`define SEC_USER_LAST     21'h000087

`endif

// ===== hw/flash_host_pkg.sv
// Types for the parallel NOR flash host controller.
// Assumes the constants header is compiled alongside.
package flash_host_pkg;

	typedef enum logic [3:0]
	{
		OP_READ         = 4'h0,
		OP_PROGRAM      = 4'h1,
		OP_SECTOR_ERASE = 4'h2,
		OP_BLOCK_ERASE  = 4'h3,
		OP_CHIP_ERASE   = 4'h4,
		OP_ID_ENTRY     = 4'h5,
		OP_QUERY_ENTRY  = 4'h6,
		OP_QUERY_SHORT  = 4'h7,
		OP_SEC_ENTRY    = 4'h8,
		OP_SEC_PROGRAM  = 4'h9,
		OP_SEC_LOCK     = 4'hA,
		OP_EXIT         = 4'hB,
		OP_EXIT_SHORT   = 4'hC,
		OP_HW_RESET     = 4'hD
	} op_t;

	typedef enum logic [2:0]
	{
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_STROBE = 3'b011,
		ST_HOLD   = 3'b010,
		ST_RESET  = 3'b110,
		ST_RECOV  = 3'b111,
		ST_DONE   = 3'b101
	} state_t;

	typedef enum logic [1:0]
	{
		MODE_ARRAY = 2'b00,
		MODE_ID    = 2'b01,
		MODE_QUERY = 2'b11,
		MODE_SEC   = 2'b10
	} mode_t;

endpackage

// ===== hw/flash_host_ctrl.sv
// Host-side controller that drives a parallel NOR flash through its pins.
// Assumes the flash pins are synchronous to clk_in; the device itself runs
// unclocked and the controller sequences every strobe in whole cycles.
`timescale 1ns/1ps
`include "flash_host_params.svh"

module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter bit BOOT_TOP = 1'b1
)
(
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        req_valid_in,
	input  wire logic [3:0]  req_op_in,
	input  wire logic [20:0] req_addr_in,
	input  wire logic [15:0] req_data_in,
	input  wire logic        wp_allow_in,
	input  wire logic        busy_in,
	input  wire logic [15:0] dq_in,
	output logic             req_ready_out,
	output logic             resp_valid_out,
	output logic [15:0]      resp_data_out,
	output logic             resp_refused_out,
	output logic [1:0]       mode_out,
	output logic             sec_locked_out,
	output logic             ce_n_out,
	output logic             oe_n_out,
	output logic             we_n_out,
	output logic             rst_n_out,
	output logic             wp_n_out,
	output logic [20:0]      addr_out,
	output logic [15:0]      dq_out,
	output logic             dq_oe_out
);

	localparam int STROBE_CYC = `STROBE_LOW_CYC;
	localparam int RESET_CYC  = `RESET_PULSE_CYC;
	localparam int RECOV_CYC  = `RELEASE_READ_CYC;
	localparam int READ_CYC   = `READ_CYCLE_CYC;

	state_t      state_q;
	op_t         op_q;
	logic [2:0]  step_q;
	logic [2:0]  steps_q;
	logic [7:0]  cnt_q;
	logic        write_q;
	logic [20:0] addr_q;
	logic [15:0] data_q;
	mode_t       mode_q;
	logic        sec_locked_q;
	logic        refuse;
	logic        in_boot;
	logic        is_sec_user;
	logic [2:0]  n_steps;
	logic [20:0] cyc_addr;
	logic [15:0] cyc_data;
	logic        last_step;
	logic        exit_op;

	// Boot block range chosen per variant
	always_comb
	begin
		if (BOOT_TOP)
			in_boot = (req_addr_in >= `BOOT_TOP_BASE);
		else
			in_boot = (req_addr_in <= `BOOT_BOTTOM_LAST);
	end

	assign is_sec_user = (req_addr_in >= `SEC_USER_FIRST) &&
		(req_addr_in <= `SEC_USER_LAST);
	assign exit_op = (req_op_in == OP_EXIT) || (req_op_in == OP_EXIT_SHORT);

	// Refused requests never reach the pins, so the device sees no write
	always_comb
	begin
		refuse = 1'b0;
		unique case (op_t'(req_op_in))
			OP_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE:
				refuse = in_boot && !wp_allow_in;
			OP_CHIP_ERASE:
				refuse = !wp_allow_in;
			OP_SEC_PROGRAM:
				refuse = !is_sec_user || sec_locked_q;
			OP_EXIT, OP_EXIT_SHORT:
				refuse = busy_in;
			// Unknown codes never start an unlock sequence on the pins
			default:
				refuse = (req_op_in > OP_HW_RESET);
		endcase
	end

	always_comb
	begin
		unique case (op_t'(req_op_in))
			OP_READ:         n_steps = 3'd1;
			OP_PROGRAM:      n_steps = 3'd4;
			OP_SEC_PROGRAM:  n_steps = 3'd4;
			OP_SEC_LOCK:     n_steps = 3'd4;
			OP_SECTOR_ERASE: n_steps = 3'd6;
			OP_BLOCK_ERASE:  n_steps = 3'd6;
			OP_CHIP_ERASE:   n_steps = 3'd6;
			OP_QUERY_SHORT:  n_steps = 3'd1;
			OP_EXIT_SHORT:   n_steps = 3'd1;
			default:         n_steps = 3'd3;
		endcase
	end

	// Address and data of bus cycle step_q of the current operation
	always_comb
	begin
		cyc_addr = `ADDR_UNLOCK1;
		cyc_data = `DATA_UNLOCK1;
		if (step_q == 3'd1 || step_q == 3'd4)
		begin
			cyc_addr = `ADDR_UNLOCK2;
			cyc_data = `DATA_UNLOCK2;
		end
		else if (step_q == 3'd2)
		begin
			unique case (op_q)
				OP_PROGRAM:     cyc_data = `CMD_PROGRAM;
				OP_SEC_PROGRAM: cyc_data = `CMD_SEC_PROGRAM;
				OP_SEC_LOCK:    cyc_data = `CMD_SEC_LOCK;
				OP_ID_ENTRY:    cyc_data = `CMD_ID_ENTRY;
				OP_QUERY_ENTRY: cyc_data = `CMD_QUERY_ENTRY;
				OP_SEC_ENTRY:   cyc_data = `CMD_SEC_ENTRY;
				OP_EXIT:        cyc_data = `CMD_EXIT;
				default:        cyc_data = `CMD_ERASE_SETUP;
			endcase
		end
		else if (step_q == 3'd3 && steps_q == 3'd4)
		begin
			cyc_addr = addr_q;
			cyc_data = (op_q == OP_SEC_LOCK) ? `DATA_LOCK_WORD : data_q;
		end
		else if (step_q == 3'd5)
		begin
			cyc_addr = (op_q == OP_CHIP_ERASE) ? `ADDR_UNLOCK1 : addr_q;
			unique case (op_q)
				OP_SECTOR_ERASE: cyc_data = `CMD_SECTOR_ERASE;
				OP_BLOCK_ERASE:  cyc_data = `CMD_BLOCK_ERASE;
				default:         cyc_data = `CMD_CHIP_ERASE;
			endcase
		end
		if (steps_q == 3'd1)
		begin
			cyc_addr = addr_q;
			unique case (op_q)
				OP_QUERY_SHORT: cyc_data = `CMD_QUERY_ENTRY;
				OP_EXIT_SHORT:  cyc_data = `CMD_EXIT;
				default:        cyc_data = data_q;
			endcase
		end
	end

	assign last_step = (step_q == steps_q - 3'd1);

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			state_q <= ST_IDLE;
			op_q    <= OP_READ;
			step_q  <= 3'd0;
			steps_q <= 3'd1;
			cnt_q   <= 8'h00;
			write_q <= 1'b0;
			addr_q  <= 21'h000000;
			data_q  <= 16'h0000;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (req_valid_in && !refuse)
					begin
						op_q    <= op_t'(req_op_in);
						steps_q <= n_steps;
						step_q  <= 3'd0;
						addr_q  <= (req_op_in == OP_QUERY_SHORT) ?
							`ADDR_QUERY_SHORT : req_addr_in;
						data_q  <= req_data_in;
						write_q <= (req_op_in != OP_READ);
						cnt_q   <= 8'h00;
						state_q <= (req_op_in == OP_HW_RESET) ?
							ST_RESET : ST_SETUP;
					end
				end
				ST_SETUP:
					state_q <= ST_STROBE;
				ST_STROBE:
				begin
					// Strobe far wider than the glitch filter
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q == 8'(((write_q ? STROBE_CYC : READ_CYC)) - 1))
					begin
						cnt_q   <= 8'h00;
						state_q <= ST_HOLD;
					end
				end
				ST_HOLD:
				begin
					if (last_step)
						state_q <= ST_DONE;
					else
					begin
						step_q  <= step_q + 3'd1;
						state_q <= ST_SETUP;
					end
				end
				ST_RESET:
				begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q == 8'(RESET_CYC - 1))
					begin
						cnt_q   <= 8'h00;
						state_q <= ST_RECOV;
					end
				end
				ST_RECOV:
				begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q == 8'(RECOV_CYC - 1))
						state_q <= ST_DONE;
				end
				ST_DONE:
					state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Pin drive; OE stays high and CE low through every write
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			ce_n_out  <= 1'b1;
			oe_n_out  <= 1'b1;
			we_n_out  <= 1'b1;
			rst_n_out <= 1'b1;
			addr_out  <= 21'h000000;
			dq_out    <= 16'h0000;
			dq_oe_out <= 1'b0;
		end
		else
		begin
			rst_n_out <= !(state_q == ST_IDLE && req_valid_in && !refuse &&
				req_op_in == OP_HW_RESET) && !(state_q == ST_RESET &&
				cnt_q != 8'(RESET_CYC - 1));
			ce_n_out  <= !(state_q == ST_SETUP || state_q == ST_STROBE);
			we_n_out  <= !(write_q && ((state_q == ST_SETUP) ||
				(state_q == ST_STROBE && cnt_q != 8'(STROBE_CYC - 1))));
			oe_n_out  <= !(!write_q && (state_q == ST_SETUP ||
				state_q == ST_STROBE));
			dq_oe_out <= write_q && (state_q == ST_SETUP ||
				state_q == ST_STROBE);
			if (state_q == ST_SETUP)
			begin
				addr_out <= cyc_addr;
				dq_out   <= cyc_data;
			end
		end
	end

	// Write protect pin; reset value high keeps the boot block open
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			wp_n_out <= 1'b1;
		else
			wp_n_out <= wp_allow_in;
	end

	// Mode tracking; read sampled on the edge at which the strobe ends
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			mode_q       <= MODE_ARRAY;
			sec_locked_q <= 1'b0;
		end
		else if (state_q == ST_DONE)
		begin
			unique case (op_q)
				OP_ID_ENTRY:    mode_q <= MODE_ID;
				OP_QUERY_ENTRY: mode_q <= MODE_QUERY;
				OP_QUERY_SHORT: mode_q <= MODE_QUERY;
				OP_SEC_ENTRY:   mode_q <= MODE_SEC;
				OP_EXIT, OP_EXIT_SHORT, OP_HW_RESET:
					mode_q <= MODE_ARRAY;
				OP_SEC_LOCK:    sec_locked_q <= 1'b1;
				default:        mode_q <= mode_q;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			req_ready_out    <= 1'b0;
			resp_valid_out   <= 1'b0;
			resp_refused_out <= 1'b0;
			resp_data_out    <= 16'h0000;
		end
		else
		begin
			req_ready_out    <= (state_q == ST_IDLE) && !req_valid_in;
			resp_valid_out   <= (state_q == ST_DONE) ||
				(state_q == ST_IDLE && req_valid_in && refuse);
			resp_refused_out <= (state_q == ST_IDLE && req_valid_in && refuse);
			if (state_q == ST_HOLD && !write_q)
				resp_data_out <= dq_in;
		end
	end

	assign mode_out       = mode_q;
	assign sec_locked_out = sec_locked_q;

endmodule

// ===== verification/flash_host_ctrl_monitor.sv
// Pin-level checker for the flash host controller.
// Assumes it is bound onto the controller; one clock domain.
`timescale 1ns/1ps
`include "flash_host_params.svh"
module flash_host_ctrl_monitor
	import flash_host_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       req_valid_in,
	input  wire logic [3:0] req_op_in,
	input  wire logic       wp_allow_in,
	input  wire logic       busy_in,
	input  wire logic       req_ready_out,
	input  wire logic       resp_valid_out,
	input  wire logic       resp_refused_out,
	input  wire logic       ce_n_out,
	input  wire logic       oe_n_out,
	input  wire logic       we_n_out,
	input  wire logic       rst_n_out,
	input  wire logic       wp_n_out,
	input  wire logic       dq_oe_out
);
	localparam int RST_CYC = `RESET_PULSE_CYC;
	localparam int RCV_CYC = `RELEASE_READ_CYC;
	int lo_q;
	int hi_q;
	logic is_exit;
	assign is_exit = req_op_in == OP_EXIT || req_op_in == OP_EXIT_SHORT;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	always_ff @(posedge clk_in)
		if (sys_rst_in || rst_n_out)
			lo_q <= 0;
		else
			lo_q <= lo_q + 1;
	// Starts saturated so a read soon after system reset is legal
	always_ff @(posedge clk_in)
		if (sys_rst_in)
			hi_q <= RCV_CYC;
		else if (!rst_n_out)
			hi_q <= 0;
		else if (hi_q < RCV_CYC)
			hi_q <= hi_q + 1;
	a_strobe_width: assert property (
		$fell(we_n_out) |-> !we_n_out [*2])
		else $error("write strobe too short");
	a_write_quiet: assert property (
		!we_n_out |-> oe_n_out && !ce_n_out)
		else $error("write strobe with bad select");
	a_dq_no_fight: assert property (dq_oe_out |-> oe_n_out)
		else $error("data driven during read");
	a_wp_follow: assert property (
		$stable(wp_allow_in) |-> ##[0:1] (wp_n_out == wp_allow_in))
		else $error("protect pin wrong");
	a_refuse_quiet: assert property (
		resp_refused_out |->
		resp_valid_out && ce_n_out && $past(ce_n_out, 2))
		else $error("refusal touched the pins");
	a_busy_exit: assert property (
		req_valid_in && req_ready_out && busy_in && is_exit |->
		##[1:2] resp_refused_out)
		else $error("exit not refused while busy");
	a_reset_pulse: assert property (
		$rose(rst_n_out) |-> lo_q >= RST_CYC)
		else $error("reset pulse too short");
	a_read_recovery: assert property (
		!oe_n_out |-> hi_q >= RCV_CYC)
		else $error("read too soon after reset");
	c_write: cover property ($rose(we_n_out));
	c_reset: cover property ($rose(rst_n_out));
	c_refuse: cover property (resp_refused_out);
endmodule

// ===== verification/flash_dev_model.sv
// Behavioural parallel NOR flash seen from its pins.
// Commands latch on the rising write strobe; no program delay.
`timescale 1ns/1ps
`include "flash_host_params.svh"
module flash_dev_model
#(
	parameter bit          BOOT_TOP = 1'b1,
	parameter logic [15:0] MAKER_ID = 16'h00A1, // Arbitrary value
	parameter logic [15:0] PART_ID  = 16'h0C3E  // Arbitrary value
)
(
	input  wire logic        ce_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        we_n_in,
	input  wire logic        rst_n_in,
	input  wire logic        wp_n_in,
	input  wire logic [20:0] addr_in,
	input  wire logic [15:0] dq_w_in,
	output logic [15:0]      dq_r_out
);
	logic [15:0] mem [int];
	logic [15:0] sec [0:135];
	logic [15:0] rd;
	logic [15:0] last_q = 16'h0000;
	logic [1:0]  md = 2'b00;
	logic        lk = 1'b0;
	int          seq = 0;
	int          s;
	realtime     t_f = 0;
	logic        wp;
	logic        boot;
	logic [10:0] a;
	logic [7:0]  d;
	initial
		foreach (sec[i])
			sec[i] = (i < 8) ? 16'h5A00 + 16'(i) : 16'hFFFF;
	assign a = addr_in[10:0];
	assign d = dq_w_in[7:0];
	assign wp = wp_n_in !== 1'b0;
	assign boot = BOOT_TOP ? addr_in >= `BOOT_TOP_BASE
		: addr_in <= `BOOT_BOTTOM_LAST;
	always @(negedge we_n_in)
		t_f = $realtime;
	always @(posedge we_n_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			md = 2'b00;
			seq = 0;
		end
		else if (!ce_n_in && oe_n_in && $realtime - t_f >= 5.0)
		begin
			s = seq;
			seq = 0;
			case (s)
			0: if (a == 11'h555 && d == 8'hAA) seq = 1;
				else if (a == 11'h055 && d == 8'h98) md = 2'b11;
				else if (d == 8'hF0) md = 2'b00;
			1: if (a == 11'h2AA && d == 8'h55) seq = 2;
			2: case (a == 11'h555 ? d : 8'h00)
				8'hA0: seq = 3;
				8'hA5: seq = 4;
				8'h85: seq = 5;
				8'h80: seq = 6;
				8'h90: md = 2'b01;
				8'h98: md = 2'b11;
				8'h88: md = 2'b10;
				8'hF0: md = 2'b00;
				default: seq = 0;
				endcase
			3: if (!(boot && !wp)) mem[addr_in] = dq_w_in;
			4: if (!lk && addr_in >= 8 && addr_in <= 135)
				sec[addr_in] = dq_w_in;
			5: lk = 1'b1;
			6: if (a == 11'h555 && d == 8'hAA) seq = 7;
			7: if (a == 11'h2AA && d == 8'h55) seq = 8;
			// Only chip erase clears; the security space is never erased
			8: if (d == 8'h10 && wp) mem.delete();
			default: seq = 0;
			endcase
		end
	// Re-evaluated on every read strobe so a word just written at an
	// unchanged address is seen; array contents are not in the list
	always @(addr_in, md, oe_n_in)
		case (md)
		2'b01: rd = addr_in[0] ? PART_ID : MAKER_ID;
		2'b10: rd = sec[addr_in[7:0]];
		default: rd = mem.exists(addr_in) ? mem[addr_in] : 16'hFFFF;
		endcase
	// Released bus shows the inverse of the last word, not a held value
	always @(posedge oe_n_in)
		last_q = rd;
	assign dq_r_out = (!ce_n_in && !oe_n_in) ? rd : ~last_q;
endmodule

// ===== verification/test_flash_host_ctrl.sv
// Self-checking bench: host controller driving the flash model.
// One 20 MHz clock; stimulus lands 2 ns after each rising edge.
`timescale 1ns/1ps
`include "flash_host_params.svh"
module test_flash_host_ctrl import flash_host_pkg::*;;
	localparam logic [15:0] MAKER = 16'h00A1; // Arbitrary value
	localparam logic [15:0] PART  = 16'h0C3E; // Arbitrary value
	logic        clk_in = 0;
	logic        sys_rst_in = 1;
	logic        req_valid_in = 0;
	logic [3:0]  req_op_in = 4'h0;
	logic [20:0] req_addr_in = 21'h0;
	logic [15:0] req_data_in = 16'h0;
	logic        wp_allow_in = 1;
	logic        busy_in = 0;
	logic [15:0] dq_in;
	logic        rdy, rv, rf, rfs, lk, ce, oe, we, rs, wpn, dqe;
	logic [15:0] rdat, dqo, rd;
	logic [1:0]  mode_out;
	logic [20:0] ad;
	int          failures = 0;
	int          n_tests = 0;
	int          cyc = 0;
	flash_host_ctrl #(.BOOT_TOP(1'b1)) dut_u (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
		.req_op_in(req_op_in), .req_addr_in(req_addr_in),
		.req_data_in(req_data_in), .wp_allow_in(wp_allow_in),
		.busy_in(busy_in), .dq_in(dq_in), .req_ready_out(rdy),
		.resp_valid_out(rv), .resp_data_out(rdat),
		.resp_refused_out(rfs), .mode_out(mode_out), .sec_locked_out(lk),
		.ce_n_out(ce), .oe_n_out(oe), .we_n_out(we), .rst_n_out(rs),
		.wp_n_out(wpn), .addr_out(ad), .dq_out(dqo), .dq_oe_out(dqe));
	flash_dev_model #(.BOOT_TOP(1'b1), .MAKER_ID(MAKER), .PART_ID(PART))
		dev_u (.ce_n_in(ce), .oe_n_in(oe), .we_n_in(we), .rst_n_in(rs),
		.wp_n_in(wpn), .addr_in(ad), .dq_w_in(dqo), .dq_r_out(dq_in));
	always #25 clk_in = ~clk_in;
	task conclude();
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// Holds the request until the response is seen, then drops it before
	// the next edge so the idle state cannot take it a second time
	task op(input logic [3:0] o, input logic [20:0] a, input logic [15:0] d);
		int n;
		@(posedge clk_in);
		#2 req_op_in = o;
		req_addr_in = a;
		req_data_in = d;
		req_valid_in = 1;
		n = 0;
		do
		begin
			@(posedge clk_in);
			#2 n++;
		end
		while (rv !== 1'b1 && n < 200);
		if (n >= 200)
			failures++;
		rf = rfs;
		rd = rdat;
		req_valid_in = 0;
	endtask
	task t_program();
		op(OP_PROGRAM, 21'h000123, 16'hBEEF);
		chk("prog ref", 16'h0, 16'(rf));
		op(OP_READ, 21'h000123, 16'h0);
		chk("prog rd", 16'hBEEF, rd);
	endtask
	task t_boot();
		wp_allow_in = 0;
		op(OP_PROGRAM, `BOOT_TOP_BASE, 16'h1111);
		chk("boot ref", 16'h1, 16'(rf));
		op(OP_PROGRAM, 21'h1F7FFF, 16'h2222);
		op(OP_READ, 21'h1F7FFF, 16'h0);
		chk("below rd", 16'h2222, rd);
		op(OP_CHIP_ERASE, 21'h0, 16'h0);
		chk("erase ref", 16'h1, 16'(rf));
		wp_allow_in = 1;
		op(OP_PROGRAM, `BOOT_TOP_BASE, 16'h1111);
		op(OP_READ, `BOOT_TOP_BASE, 16'h0);
		chk("boot rd", 16'h1111, rd);
	endtask
	task t_modes();
		op(OP_ID_ENTRY, 21'h0, 16'h0);
		op(OP_READ, 21'h0, 16'h0);
		chk("maker", MAKER, rd);
		op(OP_READ, 21'h1, 16'h0);
		chk("part", PART, rd);
		op(OP_EXIT, 21'h0, 16'h0);
		op(OP_READ, 21'h000123, 16'h0);
		chk("exit rd", 16'hBEEF, rd);
		op(OP_QUERY_ENTRY, 21'h0, 16'h0);
		chk("query", 16'(MODE_QUERY), 16'(mode_out));
		op(OP_EXIT_SHORT, 21'h0, 16'h0);
		chk("q exit", 16'(MODE_ARRAY), 16'(mode_out));
		op(OP_QUERY_SHORT, 21'h0, 16'h0);
		chk("q short", 16'(MODE_QUERY), 16'(mode_out));
		busy_in = 1;
		op(OP_EXIT, 21'h0, 16'h0);
		chk("busy ref", 16'h1, 16'(rf));
		chk("q stays", 16'(MODE_QUERY), 16'(mode_out));
		busy_in = 0;
		op(OP_EXIT, 21'h0, 16'h0);
		chk("q left", 16'(MODE_ARRAY), 16'(mode_out));
		op(4'hE, 21'h0, 16'h0);
		chk("bad op", 16'h1, 16'(rf));
	endtask
	task t_sec();
		op(OP_SEC_PROGRAM, 21'h8, 16'h00C5);
		chk("sec ref", 16'h0, 16'(rf));
		op(OP_SEC_PROGRAM, 21'h7, 16'h0001);
		chk("factory", 16'h1, 16'(rf));
		op(OP_SEC_PROGRAM, 21'h88, 16'h0001);
		chk("past end", 16'h1, 16'(rf));
		op(OP_SEC_ENTRY, 21'h0, 16'h0);
		chk("sec mode", 16'(MODE_SEC), 16'(mode_out));
		op(OP_READ, 21'h8, 16'h0);
		chk("sec rd", 16'h00C5, rd);
		op(OP_SEC_LOCK, 21'h0, 16'h0);
		chk("locked", 16'h1, 16'(lk));
		op(OP_SEC_PROGRAM, 21'h9, 16'h0002);
		chk("lock ref", 16'h1, 16'(rf));
		op(OP_EXIT, 21'h0, 16'h0);
		chk("sec left", 16'(MODE_ARRAY), 16'(mode_out));
	endtask
	task t_reset();
		op(OP_ID_ENTRY, 21'h0, 16'h0);
		op(OP_HW_RESET, 21'h0, 16'h0);
		chk("rst mode", 16'(MODE_ARRAY), 16'(mode_out));
		op(OP_READ, 21'h000123, 16'h0);
		chk("rst rd", 16'hBEEF, rd);
		// A program still busy when the reset is issued is issued again afterwards
		op(OP_PROGRAM, 21'h000200, 16'h1234);
		busy_in = 1;
		op(OP_HW_RESET, 21'h0, 16'h0);
		busy_in = 0;
		op(OP_PROGRAM, 21'h000200, 16'h1234);
		op(OP_READ, 21'h000200, 16'h0);
		chk("reissue", 16'h1234, rd);
		op(OP_CHIP_ERASE, 21'h0, 16'h0);
		op(OP_READ, 21'h000123, 16'h0);
		chk("erased", 16'hFFFF, rd);
		op(OP_SEC_ENTRY, 21'h0, 16'h0);
		op(OP_READ, 21'h8, 16'h0);
		chk("sec kept", 16'h00C5, rd);
	endtask
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			failures++;
			conclude();
		end
	end
	initial
	begin
		repeat (6) @(posedge clk_in);
		#2 sys_rst_in = 0;
		t_program();
		t_boot();
		t_modes();
		t_sec();
		t_reset();
		conclude();
	end
endmodule
bind flash_host_ctrl flash_host_ctrl_monitor mon_u (.clk_in(clk_in),
	.sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
	.req_op_in(req_op_in), .wp_allow_in(wp_allow_in), .busy_in(busy_in),
	.req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out),
	.resp_refused_out(resp_refused_out), .ce_n_out(ce_n_out),
	.oe_n_out(oe_n_out), .we_n_out(we_n_out), .rst_n_out(rst_n_out),
	.wp_n_out(wp_n_out), .dq_oe_out(dq_oe_out));
